/* File: logic/ias_sequencer.sv */
// interrupt acknowledge sequencer with failsafe bus timer
// assumes every input except the clock is asynchronous to clk_sys
`timescale 1ns/1ps
module ias_sequencer
#(
   parameter int unsigned TIMEOUT = ias_pkg::TIMEOUT_CYC,
   parameter int unsigned TAP = ias_pkg::WAIT_TAP
)(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [2:0] cpu_status,
   input wire logic irq_line_five,
   input wire logic irq_line_six,
   input wire logic line_six_remote,
   input wire logic service_done,
   input wire logic ext_ack_jumper,
   input wire logic timeout_jumper,
   input wire logic sysbus_addr_enable_n,
   input wire logic bus_hold_n,
   input wire logic xack_n,
   input wire logic ale,
   output logic cpu_int_request,
   output logic master_cascade_enable,
   output logic ack_cycle_flag,
   output logic sysbus_request,
   output logic sysbus_ack_n,
   output logic int_ack_strobe_n,
   output logic onboard_addr_n,
   output logic onboard_ack_active,
   output logic first_ack_n,
   output logic offboard_ready,
   output logic pic_enable_out_n,
   output logic pic_data_enable,
   output logic [7:0] data_out,
   output logic [2:0] cascade_lines,
   output logic [2:0] sysbus_addr_hi,
   output logic bus_timeout_irq_n
);
   import ias_pkg::*;

   // two-flop synchronisers for all pins except clock and reset; s1 feeds only s2
   localparam int NS = 13;
   logic [NS-1:0] s1;
   logic [NS-1:0] s2;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= SYNC_RST;
         s2 <= SYNC_RST;
      end
      else
      begin
         s1 <= {bus_hold_n, xack_n, sysbus_addr_enable_n, ext_ack_jumper, timeout_jumper, line_six_remote,
                irq_line_five, irq_line_six, service_done, ale, cpu_status};
         s2 <= s1;
      end
   end

   // synchronised views
   logic [2:0] stat;
   logic ale_s, done_s, ir6_s, ir5_s, six_rem_s, tjump_s, ejump_s, aen_n_s, xack_n_s, hold_n_s;
   assign {hold_n_s, xack_n_s, aen_n_s, ejump_s, tjump_s, six_rem_s, ir5_s, ir6_s, done_s, ale_s, stat} = s2;

   // status decode, cpu drives all three lines low
   function automatic logic is_ack(input logic [2:0] st);
      is_ack = (st == STAT_ACK);
   endfunction : is_ack
   logic ack_stat;
   assign ack_stat = is_ack(stat);

   // previous values for edge detection
   logic ale_d, done_d;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         {ale_d, done_d} <= 2'h0;
      else
         {ale_d, done_d} <= {ale_s, done_s};
   end

   // acknowledge state machine
   ias_state_t state, next_state;
   logic in_ack1, in_ack2, strobe;
   assign in_ack1 = (state == ST_ACK1);
   assign in_ack2 = (state == ST_ACK2);
   assign strobe = (in_ack1 | in_ack2) & ack_stat;

   // serviced line captured every idle cycle and held once the state leaves ST_IDLE, 1 means line six
   logic svc_six;
   logic frozen;
   logic remote_vector_mode;
   logic local_vector_mode;
   assign remote_vector_mode = svc_six & six_rem_s;
   assign local_vector_mode = ~remote_vector_mode;

   // next-state logic
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            // jumper fitted routes the acknowledge through the system bus
            if (ack_stat)
               next_state = ejump_s ? ST_ARB : ST_ACK1;
         end
         ST_ARB:
         begin
            // wait for the arbiter to hand over the bus
            if (!aen_n_s)
               next_state = ST_ACK1;
            else if (!ack_stat)
               next_state = ST_IDLE;
         end
         ST_ACK1:
            // first cycle ends when status goes passive
            if (!ack_stat)
               next_state = ST_GAP;
         ST_GAP:
            // bus stays held by the cpu, so go straight to cycle two
            if (ack_stat)
               next_state = ST_ACK2;
         ST_ACK2:
            // second cycle over, back to idle
            if (!ack_stat)
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // acknowledge qualifiers
   always_comb
   begin
      master_cascade_enable = ack_stat;
      ack_cycle_flag = master_cascade_enable | (state != ST_IDLE);
      sysbus_request = (ack_cycle_flag | ~hold_n_s) & ejump_s;
      onboard_addr_n = ~(ack_cycle_flag & ~ejump_s);
      sysbus_ack_n = ~(strobe & ejump_s & ~aen_n_s);
      int_ack_strobe_n = ~(strobe & ~ejump_s);
   end

   // failsafe timer
   logic [TMR_W-1:0] tmr;
   logic timed_out;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         tmr <= '0;
      else if (ale_s & ~ale_d)
         tmr <= '0;
      else if (tmr != TMR_W'(TIMEOUT))
         tmr <= tmr + 1'b1;
   end
   assign timed_out = (tmr == TMR_W'(TIMEOUT));

   // timeout output, usable through the interrupt matrix
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         bus_timeout_irq_n <= 1'b1; // idle high, active low
      else
         bus_timeout_irq_n <= ~timed_out;
   end

   // onboard acknowledge: local path, bus path, or forced by timeout
   assign onboard_ack_active = (~onboard_addr_n & ~int_ack_strobe_n)
      | (~aen_n_s & ~sysbus_ack_n)
      | (~bus_timeout_irq_n & tjump_s);

   // wait-state shift register fed by the onboard acknowledge
   logic [WAIT_LEN-1:0] wait_sr;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wait_sr <= '0;
      else
         wait_sr <= {wait_sr[WAIT_LEN-2:0], onboard_ack_active};
   end
   logic tap;
   assign tap = wait_sr[TAP];

   // first-ack flag, set in cycle one, cleared back at idle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         first_ack_n <= 1'b1;
      else if (in_ack1 & onboard_ack_active)
         first_ack_n <= 1'b0;
      else if (state == ST_IDLE)
         first_ack_n <= 1'b1;
   end

   // local vector enable for the second strobe
   assign pic_enable_out_n = ~(in_ack2 & strobe & local_vector_mode);
   assign pic_data_enable = ~pic_enable_out_n;

   // ready return to the cpu
   assign offboard_ready = (~first_ack_n & in_ack1 & tap)
      | (pic_data_enable & tap)
      | (in_ack2 & remote_vector_mode & ~xack_n_s)
      | (~bus_timeout_irq_n & tjump_s);

   // priority: line five above line six; in-service bits
   logic [1:0] in_service;
   logic req5, req6;
   assign req5 = ir5_s & ~in_service[0];
   assign req6 = ir6_s & ~in_service[1] & ~in_service[0];

   // freeze flag and serviced line capture
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frozen <= 1'b0;
         svc_six <= 1'b0;
      end
      else if (state == ST_IDLE)
      begin
         frozen <= 1'b0;
         svc_six <= ~req5 & req6;
      end
      else if (in_ack1 & strobe)
         frozen <= 1'b1;
   end

   // interrupt request to the cpu, forced low while frozen
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cpu_int_request <= 1'b0;
      else if (!frozen)
         cpu_int_request <= (req5 | req6) & (state == ST_IDLE);
      else
         cpu_int_request <= 1'b0;
   end

   // in-service bits: set at second strobe, cleared on service done
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         in_service <= IN_SERVICE_RST;
      else
      begin
         if (done_s & ~done_d)
            in_service <= in_service[0] ? {in_service[1], 1'b0} : 2'h0; // highest priority retires first
         if (in_ack2 & strobe)
            in_service <= svc_six ? {1'b1, in_service[0]} : {in_service[1], 1'b1};
      end
   end

   // vector byte on the low data lines in local mode
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         data_out <= VEC_RST;
      else if (!pic_enable_out_n)
         data_out <= VEC_BASE + {7'h00, svc_six};
      else
         data_out <= VEC_RST;
   end

   // slave id on cascade lines and gated to address bits 8..10
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cascade_lines <= 3'h0;
         sysbus_addr_hi <= 3'h0;
      end
      else
      begin
         cascade_lines <= (remote_vector_mode & (~sysbus_ack_n | in_ack2)) ? SLAVE_ID : 3'h0;
         sysbus_addr_hi <= (master_cascade_enable & in_ack2 & remote_vector_mode) ? cascade_lines : 3'h0;
      end
   end

   // sequences for the checks below
   sequence ack_start_s;
      state == ST_IDLE && ack_stat;
   endsequence
   sequence ack_end_s;
      in_ack2 && !ack_stat;
   endsequence

   // status decode raises cascade enable
   cascade_on_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ack_stat |-> master_cascade_enable && ack_cycle_flag && sysbus_request == ejump_s)
      else $error("cascade enable missing on acknowledge status");
   // jumper removed keeps onboard address low
   local_path_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ack_start_s ##0 !ejump_s |=> onboard_addr_n == 1'b0 || !ack_cycle_flag)
      else $error("onboard address not low on local acknowledge");
   // bus acknowledge only with the bus granted
   bus_ack_grant_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !sysbus_ack_n |-> !aen_n_s && ejump_s)
      else $error("bus acknowledge without grant");
   // jumper fitted keeps onboard address inactive
   remote_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ejump_s |-> onboard_addr_n)
      else $error("onboard address active with jumper fitted");
   // first acknowledge sets the flag next edge
   first_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      in_ack1 && onboard_ack_active |=> !first_ack_n)
      else $error("first acknowledge flag not set");
   // flags clear one edge after the return to idle, two edges after the sequence ends
   seq_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ack_end_s |=> state == ST_IDLE ##1 first_ack_n && !frozen)
      else $error("acknowledge logic did not return to idle");
   // first strobe freezes priority and drops the request
   freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      in_ack1 && strobe |=> frozen ##1 !cpu_int_request)
      else $error("priority not frozen on first strobe");
   // transfer ack in remote cycle two gives ready
   xack_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      in_ack2 && remote_vector_mode && !xack_n_s |-> offboard_ready)
      else $error("ready missing on transfer acknowledge");
   // ale restarts the timer
   ale_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ale_s && !ale_d |=> tmr == '0 ##1 bus_timeout_irq_n)
      else $error("timer not restarted by ale");
   // timeout with jumper forces ready
   timeout_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !bus_timeout_irq_n && tjump_s |-> onboard_ack_active && offboard_ready)
      else $error("timeout did not release the cpu");
   // local enable marks data enable
   local_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !pic_enable_out_n |-> pic_data_enable ##1 data_out[7:1] == VEC_BASE[7:1])
      else $error("local vector enable without data");
endmodule : ias_sequencer

/* File: logic/ias_pkg.sv */
// constants shared by the interrupt acknowledge sequencer
// assumes a single 200 MHz cpu clock and active-low async reset
package ias_pkg;
   // cpu clock rate in MHz
   localparam int unsigned CLK_MHZ = 200;
   // failsafe timeout interval in microseconds
   localparam int unsigned TIMEOUT_US = 4000;
   // failsafe timeout in clock cycles
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
   // width of the failsafe counter
   localparam int unsigned TMR_W = 20;
   // bus status code meaning interrupt acknowledge
   localparam logic [2:0] STAT_ACK = 3'h0;
   // wait-state shift register length and default tap
   localparam int unsigned WAIT_LEN = 4;
   localparam int unsigned WAIT_TAP = 2;
   // vector base placed on the low data byte, arbitrary
   localparam logic [7:0] VEC_BASE = 8'h40;
   // slave identifier for the line six cascade, arbitrary
   localparam logic [2:0] SLAVE_ID = 3'h6;
   // values after reset
   localparam logic [1:0] IN_SERVICE_RST = 2'h0;
   localparam logic [7:0] VEC_RST = 8'h00;
   // synchroniser idle pattern: status 111, ale 0, strobes high, jumpers 0
   localparam logic [12:0] SYNC_RST = 13'h1C07;
   // acknowledge sequence states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ARB = 3'b001,
      ST_ACK1 = 3'b010,
      ST_GAP = 3'b011,
      ST_ACK2 = 3'b100
   } ias_state_t;
endpackage : ias_pkg

/* File: tb/ias_far_side.sv */
// model of the system bus arbiter and one remote slave controller
// assumes one clock shared with the sequencer; lag sets its reply delay
`timescale 1ns/1ps
module ias_far_side (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [3:0] lag,
   input wire logic slave_pending,
   input wire logic sysbus_request,
   input wire logic sysbus_ack_n,
   output logic sysbus_addr_enable_n,
   output logic xack_n
);
   int gcnt; // cycles the request has waited
   int xcnt; // cycles the second strobe has waited
   int acks; // strobes seen in this sequence
   logic strobe_d; // strobe one cycle ago
   logic frozen; // slave priority state held
   // arbiter grants after lag, drops grant with the request
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gcnt <= 0;
         sysbus_addr_enable_n <= 1'h1;
      end
      else
      begin
         gcnt <= sysbus_request ? gcnt + 1 : 0;
         sysbus_addr_enable_n <= #1 !(sysbus_request && gcnt >= lag);
      end
   end
   // slave counts strobes, freezes on the first, answers the second
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acks <= 0;
         xcnt <= 0;
         strobe_d <= 1'h1;
         frozen <= 1'h0;
         xack_n <= 1'h1;
      end
      else
      begin
         strobe_d <= sysbus_ack_n;
         if (!sysbus_request)
            acks <= 0;
         else if (strobe_d && !sysbus_ack_n)
            acks <= acks + 1;
         frozen <= acks > 0;
         xcnt <= (acks == 2 && !sysbus_ack_n) ? xcnt + 1 : 0;
         // released line is pulled up, so it reads high
         xack_n <= #1 !(slave_pending && frozen && acks == 2 && !sysbus_ack_n && xcnt >= lag);
      end
   end
endmodule : ias_far_side

/* File: tb/tb_interrupt_ack_sequencer.sv */
// self-checking bench for the interrupt acknowledge sequencer
// assumes the far side model and a short failsafe count
`timescale 1ns/1ps
module tb_interrupt_ack_sequencer;
   import ias_pkg::*;
   localparam int TMO = 50; // shortened failsafe count
   logic clk_sys = 0, rst_n = 0, irq_line_five = 0, irq_line_six = 0, line_six_remote = 0;
   logic service_done = 0, ext_ack_jumper = 0, timeout_jumper = 0, bus_hold_n = 1, ale = 0;
   logic [2:0] cpu_status = 3'h7;
   logic [3:0] lag = 4'h1;
   logic sysbus_addr_enable_n, xack_n, cpu_int_request, master_cascade_enable, ack_cycle_flag;
   logic sysbus_request, sysbus_ack_n, int_ack_strobe_n, onboard_addr_n, onboard_ack_active;
   logic first_ack_n, offboard_ready, pic_enable_out_n, pic_data_enable, bus_timeout_irq_n;
   logic [7:0] data_out;
   logic [2:0] cascade_lines, sysbus_addr_hi;
   logic onb_lo, strb_lo, bad_ack, bus_used, pic_lo, oaa, sak; // seen during a sequence
   logic ale_run = 1; // ale generator on
   int fail_count = 0, compares = 0, cyc = 0, n;
   int last_ale = 0; // cycle at which the last ale pulse was launched
   int in_svc[2] = '{0, 0}; // model in-service bits
   always #2.5 clk_sys = !clk_sys;
   ias_sequencer #(.TIMEOUT(TMO), .TAP(WAIT_TAP)) i_ias_sequencer (.*);
   ias_far_side i_ias_far_side (.clk_sys(clk_sys), .rst_n(rst_n), .lag(lag),
      .slave_pending(irq_line_six & line_six_remote), .sysbus_request(sysbus_request),
      .sysbus_ack_n(sysbus_ack_n), .sysbus_addr_enable_n(sysbus_addr_enable_n), .xack_n(xack_n));
   // ale pulses, watchdog and sequence monitors
   always @(posedge clk_sys)
   begin
      cyc++;
      ale <= #1 ale_run && (cyc % 8 == 0);
      if (ale_run && (cyc % 8 == 0))
         last_ale = cyc;
      onb_lo <= onb_lo | !onboard_addr_n;
      strb_lo <= strb_lo | !int_ack_strobe_n;
      bad_ack <= bad_ack | (!sysbus_ack_n && sysbus_addr_enable_n);
      bus_used <= bus_used | sysbus_request;
      pic_lo <= pic_lo | (!pic_enable_out_n && pic_data_enable);
      oaa <= oaa | onboard_ack_active;
      sak <= sak | !sysbus_ack_n;
      if (cyc == 5000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   task tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : tick
   task chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t flag got %b exp %b", $time, got, exp);
      end
   endtask : chk_bit
   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t byte got %h exp %h", $time, got, exp);
      end
   endtask : chk_byte
   // one acknowledge cycle: status low, then wait for ready
   task ack_cycle;
      cpu_status = STAT_ACK;
      tick(2);
      for (n = 0; n < 60 && offboard_ready !== 1'h1; n++) tick(1);
   endtask : ack_cycle
   task run_ack(input int line, input logic jmp);
      logic [7:0] exp_vec;
      logic rem;
      exp_vec = VEC_BASE + 8'(line);
      rem = line == 1 && line_six_remote;
      {onb_lo, strb_lo, bad_ack, bus_used, pic_lo, oaa, sak} = '0;
      bus_hold_n = !jmp;
      ack_cycle();
      chk_bit(offboard_ready, 1'h1);
      chk_bit(first_ack_n, 1'h0);
      chk_bit(master_cascade_enable, 1'h1);
      chk_bit(cpu_int_request, 1'h0);
      cpu_status = 3'h7;
      tick(3 + $urandom_range(3));
      ack_cycle();
      if (rem)
         chk_bit(offboard_ready, 1'h1);
      else
         chk_bit(offboard_ready, 1'h1);
      tick(1);
      if (rem)
      begin
         chk_byte({5'h00, sysbus_addr_hi}, {5'h00, SLAVE_ID});
         chk_byte({5'h00, cascade_lines}, {5'h00, SLAVE_ID});
      end
      else
      begin
         chk_byte(data_out, exp_vec);
         chk_bit({data_out, 2'h0} == 10'(exp_vec) * 10'h004, 1'h1);
      end
      cpu_status = 3'h7;
      for (n = 0; n < 20 && first_ack_n !== 1'h1; n++) tick(1);
      chk_bit(first_ack_n, 1'h1);
      chk_bit(ack_cycle_flag, 1'h0);
      chk_bit(onb_lo, !jmp);
      chk_bit(strb_lo, !jmp);
      chk_bit(bus_used, jmp);
      chk_bit(bad_ack, 1'h0);
      chk_bit(sak, jmp);
      chk_bit(oaa, 1'h1);
      chk_bit(pic_lo, !rem);
      in_svc[line] = 1;
      bus_hold_n = 1'h1;
   endtask : run_ack
   task tally_and_finish;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      void'($urandom(32'h0ff1));
      tick(6);
      rst_n = 1'h1;
      tick(2);
      // line five local, line six via bus, line six remote, line five via bus
      for (int s = 0; s < 4; s++)
      begin
         lag = 4'($urandom_range(1, 6));
         ext_ack_jumper = s != 0;
         line_six_remote = s == 2;
         if (s % 3 == 0)
            irq_line_five = 1'h1;
         else
            irq_line_six = 1'h1;
         for (n = 0; n < 20 && cpu_int_request !== 1'h1; n++) tick(1);
         chk_bit(cpu_int_request, 1'h1);
         run_ack((s % 3 == 0) ? 0 : 1, ext_ack_jumper);
         {irq_line_five, irq_line_six} = 2'h0;
         if (in_svc[0] == 1)
         begin
            irq_line_six = 1'h1;
            tick(10);
            chk_bit(cpu_int_request, 1'h0);
            irq_line_six = 1'h0;
         end
         service_done = 1'h1;
         tick(2);
         service_done = 1'h0;
         in_svc = '{0, 0};
         tick(4);
         $display("test ack %0d done", s);
      end
      // failsafe: stop ale and time the timeout
      ale_run = 1'h0;
      for (n = 0; n < 100 && bus_timeout_irq_n !== 1'h0; n++) tick(1);
      // two sync edges, one detect edge, count to TMO, one output edge
      chk_bit(cyc - last_ale == TMO + 4, 1'h1);
      chk_bit(offboard_ready, 1'h0);
      timeout_jumper = 1'h1;
      tick(3);
      chk_bit(offboard_ready, 1'h1);
      chk_bit(onboard_ack_active, 1'h1);
      chk_bit(bus_timeout_irq_n, 1'h0);
      ale_run = 1'h1;
      timeout_jumper = 1'h0;
      for (n = 0; n < 20 && bus_timeout_irq_n !== 1'h1; n++) tick(1);
      chk_bit(bus_timeout_irq_n, 1'h1);
      $display("test timeout done");
      tally_and_finish();
   end
endmodule : tb_interrupt_ack_sequencer
